// File: hw/pmic_interrupt_mask_bank.v
// Interrupt mask bank: two mask registers, matching event flags and the interrupt request
`timescale 1ns/1ps
`include "int_mask_defs.vh"

module pmic_interrupt_mask_bank #(
  parameter IDX_W = `IDX_W,
  parameter REG_W = `REG_W
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire             clk_en,
  // Register port from the serial control link decoder
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [IDX_W-1:0] reg_idx,
  input  wire [REG_W-1:0] reg_wdata,
  output wire [REG_W-1:0] reg_rdata,
  output wire             reg_rd_valid,
  output wire             reg_idx_err,
  // Pulse-type events, one cycle per occurrence
  input  wire             prereg_overcurrent_evt,
  input  wire             core_buck_overcurrent_evt,
  input  wire             aux_buck_overcurrent_evt,
  input  wire             linear_overcurrent_evt,
  input  wire             core_buck_thermal_shutdown_evt,
  input  wire             aux_buck_thermal_shutdown_evt,
  input  wire             linear_thermal_shutdown_evt,
  input  wire             prereg_feedback_ov_evt,
  input  wire             battery_supply_uv7_evt,
  input  wire             pre_regulator_uv_high_evt,
  input  wire             battery_supply_uv_low_evt,
  input  wire             battery_supply_uv_high_evt,
  // Level indications; every transition is an event
  input  wire             internal_supply_uv_high,
  input  wire             com_error,
  input  wire             first_wake_input,
  input  wire             second_wake_input,
  // Interrupt request and mask state for the pin logic
  output wire             int_req,
  output wire [REG_W-1:0] regulator_fault_interrupt_mask,
  output wire [REG_W-1:0] supply_wake_interrupt_mask
);

  localparam LSB = `REG_LSB;

  // ==========================================================================
  // Data-bit position of each source inside the 16-bit word
  // ==========================================================================
  localparam BIT_PREREG_OC         = `POS_PREREG_OC - LSB;
  localparam BIT_CORE_BUCK_OC      = `POS_CORE_BUCK_OC - LSB;
  localparam BIT_AUX_BUCK_OC       = `POS_AUX_BUCK_OC - LSB;
  localparam BIT_LINEAR_OC         = `POS_LINEAR_OC - LSB;
  localparam BIT_CORE_BUCK_THERMAL = `POS_CORE_BUCK_THERMAL - LSB;
  localparam BIT_AUX_BUCK_THERMAL  = `POS_AUX_BUCK_THERMAL - LSB;
  localparam BIT_LINEAR_THERMAL    = `POS_LINEAR_THERMAL - LSB;
  localparam BIT_INT_SUPPLY_UVH    = `POS_INT_SUPPLY_UVH - LSB;
  localparam BIT_COM_ERROR         = `POS_COM_ERROR - LSB;
  localparam BIT_PREREG_FB_OV      = `POS_PREREG_FB_OV - LSB;
  localparam BIT_BATTERY_UV7       = `POS_BATTERY_UV7 - LSB;
  localparam BIT_UVH_A             = `POS_UVH_A - LSB;
  localparam BIT_BATTERY_UVL       = `POS_BATTERY_UVL - LSB;
  localparam BIT_UVH_B             = `POS_UVH_B - LSB;
  localparam BIT_FIRST_WAKE        = `POS_FIRST_WAKE - LSB;
  localparam BIT_SECOND_WAKE       = `POS_SECOND_WAKE - LSB;

  // ==========================================================================
  // Register port decode
  // ==========================================================================
  wire sel_fault_mask;
  wire sel_wake_mask;
  wire sel_fault_flag;
  wire sel_wake_flag;
  wire sel_any;

  // Flag indices only clear bits on a write; nothing sets a flag from the bus
  assign sel_fault_mask = (reg_idx == `IDX_REG_FAULT_MASK);
  assign sel_wake_mask  = (reg_idx == `IDX_SUPPLY_WAKE_MASK);
  assign sel_fault_flag = (reg_idx == `IDX_REG_FAULT_FLAG);
  assign sel_wake_flag  = (reg_idx == `IDX_SUPPLY_WAKE_FLAG);
  assign sel_any        = sel_fault_mask | sel_wake_mask | sel_fault_flag | sel_wake_flag;

  // ==========================================================================
  // Mask registers
  // ==========================================================================
  wire [REG_W-1:0] fault_mask;
  wire [REG_W-1:0] wake_mask;

  // A write while clk_en is low is lost; the host has to repeat it
  // Reset value is all zero, so nothing is masked after power-up
  mask_register #(
    .WIDTH     (REG_W),
    .IMPL_BITS (`REG_FAULT_BITS),
    .RST_VAL   (`MASK_RESET)
  ) u_fault_mask (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_fault_mask),
    .wr_data (reg_wdata),
    .mask    (fault_mask)
  );

  mask_register #(
    .WIDTH     (REG_W),
    .IMPL_BITS (`SUPPLY_WAKE_BITS),
    .RST_VAL   (`MASK_RESET)
  ) u_wake_mask (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .wr_en   (reg_wr & sel_wake_mask),
    .wr_data (reg_wdata),
    .mask    (wake_mask)
  );

  assign regulator_fault_interrupt_mask = fault_mask;
  assign supply_wake_interrupt_mask     = wake_mask;

  // ==========================================================================
  // Transition detection on level indications
  // ==========================================================================
  // Previous samples start unknown to software; the first enabled cycle after
  // reset only primes them, so a level that is already high is not an event
  reg  [3:0] level_prev_q;
  reg        primed_q;
  wire [3:0] level_now;
  wire [3:0] level_toggle;

  assign level_now = {second_wake_input, first_wake_input, com_error, internal_supply_uv_high};

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      level_prev_q <= 4'h0;
      primed_q     <= 1'b0;
    end else if (clk_en) begin
      level_prev_q <= level_now;
      primed_q     <= 1'b1;
    end
  end

  // Both rising and falling edges count
  assign level_toggle = primed_q ? (level_now ^ level_prev_q) : 4'h0;

  // ==========================================================================
  // Event vectors aligned with the mask bits
  // ==========================================================================
  reg [REG_W-1:0] fault_evt;
  reg [REG_W-1:0] wake_evt;

  always @* begin
    fault_evt = {REG_W{1'b0}};
    fault_evt[BIT_PREREG_OC]         = prereg_overcurrent_evt;
    fault_evt[BIT_CORE_BUCK_OC]      = core_buck_overcurrent_evt;
    fault_evt[BIT_AUX_BUCK_OC]       = aux_buck_overcurrent_evt;
    fault_evt[BIT_LINEAR_OC]         = linear_overcurrent_evt;
    fault_evt[BIT_CORE_BUCK_THERMAL] = core_buck_thermal_shutdown_evt;
    fault_evt[BIT_AUX_BUCK_THERMAL]  = aux_buck_thermal_shutdown_evt;
    fault_evt[BIT_LINEAR_THERMAL]    = linear_thermal_shutdown_evt;
  end

  always @* begin
    wake_evt = {REG_W{1'b0}};
    wake_evt[BIT_INT_SUPPLY_UVH] = level_toggle[0];
    wake_evt[BIT_COM_ERROR]      = level_toggle[1];
    wake_evt[BIT_PREREG_FB_OV]   = prereg_feedback_ov_evt;
    wake_evt[BIT_BATTERY_UV7]    = battery_supply_uv7_evt;
    // Position 12 follows the pre-regulator, position 10 the battery supply
    wake_evt[BIT_UVH_A]          = pre_regulator_uv_high_evt;
    wake_evt[BIT_BATTERY_UVL]    = battery_supply_uv_low_evt;
    wake_evt[BIT_UVH_B]          = battery_supply_uv_high_evt;
    wake_evt[BIT_FIRST_WAKE]     = level_toggle[2];
    wake_evt[BIT_SECOND_WAKE]    = level_toggle[3];
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  // Flag and mask of one source share a bit position
  // Flags latch whatever the mask says; only the request is gated
  wire [REG_W-1:0] fault_flag;
  wire [REG_W-1:0] wake_flag;

  sticky_flags #(
    .WIDTH     (REG_W),
    .IMPL_BITS (`REG_FAULT_BITS),
    .RST_VAL   (`FLAG_RESET)
  ) u_fault_flags (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .set_evt  (fault_evt),
    .clr_en   (reg_wr & sel_fault_flag),
    .clr_data (reg_wdata),
    .flags    (fault_flag)
  );

  sticky_flags #(
    .WIDTH     (REG_W),
    .IMPL_BITS (`SUPPLY_WAKE_BITS),
    .RST_VAL   (`FLAG_RESET)
  ) u_wake_flags (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .set_evt  (wake_evt),
    .clr_en   (reg_wr & sel_wake_flag),
    .clr_data (reg_wdata),
    .flags    (wake_flag)
  );

  // ==========================================================================
  // Interrupt gating
  // ==========================================================================
  wire [REG_W-1:0] fault_pass;
  wire [REG_W-1:0] wake_pass;
  wire             int_d;
  reg              int_q;

  assign fault_pass[`POS_PREREG_OC - LSB]         = fault_flag[`POS_PREREG_OC - LSB] &
                                                   ~fault_mask[`POS_PREREG_OC - LSB];
  assign fault_pass[`POS_CORE_BUCK_OC - LSB]      = fault_flag[`POS_CORE_BUCK_OC - LSB] &
                                                   ~fault_mask[`POS_CORE_BUCK_OC - LSB];
  assign fault_pass[`POS_AUX_BUCK_OC - LSB]       = fault_flag[`POS_AUX_BUCK_OC - LSB] &
                                                   ~fault_mask[`POS_AUX_BUCK_OC - LSB];
  assign fault_pass[`POS_LINEAR_OC - LSB]         = fault_flag[`POS_LINEAR_OC - LSB] &
                                                   ~fault_mask[`POS_LINEAR_OC - LSB];
  assign fault_pass[`POS_CORE_BUCK_THERMAL - LSB] = fault_flag[`POS_CORE_BUCK_THERMAL - LSB] &
                                                   ~fault_mask[`POS_CORE_BUCK_THERMAL - LSB];
  assign fault_pass[`POS_AUX_BUCK_THERMAL - LSB]  = fault_flag[`POS_AUX_BUCK_THERMAL - LSB] &
                                                   ~fault_mask[`POS_AUX_BUCK_THERMAL - LSB];
  assign fault_pass[`POS_LINEAR_THERMAL - LSB]    = fault_flag[`POS_LINEAR_THERMAL - LSB] &
                                                   ~fault_mask[`POS_LINEAR_THERMAL - LSB];
  // Unused positions carry no source
  assign fault_pass[0]  = 1'b0;
  assign fault_pass[3]  = 1'b0;
  assign fault_pass[5]  = 1'b0;
  assign fault_pass[6]  = 1'b0;
  assign fault_pass[7]  = 1'b0;
  assign fault_pass[8]  = 1'b0;
  assign fault_pass[11] = 1'b0;
  assign fault_pass[13] = 1'b0;
  assign fault_pass[15] = 1'b0;

  assign wake_pass[`POS_INT_SUPPLY_UVH - LSB] = wake_flag[`POS_INT_SUPPLY_UVH - LSB] &
                                               ~wake_mask[`POS_INT_SUPPLY_UVH - LSB];
  assign wake_pass[`POS_COM_ERROR - LSB]      = wake_flag[`POS_COM_ERROR - LSB] &
                                               ~wake_mask[`POS_COM_ERROR - LSB];
  assign wake_pass[`POS_PREREG_FB_OV - LSB]   = wake_flag[`POS_PREREG_FB_OV - LSB] &
                                               ~wake_mask[`POS_PREREG_FB_OV - LSB];
  assign wake_pass[`POS_BATTERY_UV7 - LSB]    = wake_flag[`POS_BATTERY_UV7 - LSB] &
                                               ~wake_mask[`POS_BATTERY_UV7 - LSB];
  assign wake_pass[`POS_UVH_A - LSB]          = wake_flag[`POS_UVH_A - LSB] &
                                               ~wake_mask[`POS_UVH_A - LSB];
  assign wake_pass[`POS_BATTERY_UVL - LSB]    = wake_flag[`POS_BATTERY_UVL - LSB] &
                                               ~wake_mask[`POS_BATTERY_UVL - LSB];
  assign wake_pass[`POS_UVH_B - LSB]          = wake_flag[`POS_UVH_B - LSB] &
                                               ~wake_mask[`POS_UVH_B - LSB];
  assign wake_pass[`POS_FIRST_WAKE - LSB]     = wake_flag[`POS_FIRST_WAKE - LSB] &
                                               ~wake_mask[`POS_FIRST_WAKE - LSB];
  assign wake_pass[`POS_SECOND_WAKE - LSB]    = wake_flag[`POS_SECOND_WAKE - LSB] &
                                               ~wake_mask[`POS_SECOND_WAKE - LSB];
  assign wake_pass[5]  = 1'b0;
  assign wake_pass[7]  = 1'b0;
  assign wake_pass[11] = 1'b0;
  assign wake_pass[12] = 1'b0;
  assign wake_pass[13] = 1'b0;
  assign wake_pass[14] = 1'b0;
  assign wake_pass[15] = 1'b0;

  // Setting a mask bit drops the request one cycle later; the flag stays
  assign int_d = (|fault_pass) | (|wake_pass);

  // Registered so the pin never glitches while mask and flag change together
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_q <= 1'b0;
    end else if (clk_en) begin
      int_q <= int_d;
    end
  end

  assign int_req = int_q;

  // ==========================================================================
  // Read-back
  // ==========================================================================
  reg [REG_W-1:0] rd_mux;
  reg [REG_W-1:0] rdata_q;
  reg             rd_valid_q;
  reg             idx_err_q;

  always @* begin
    case (reg_idx)
      `IDX_REG_FAULT_MASK:   rd_mux = fault_mask;
      `IDX_SUPPLY_WAKE_MASK: rd_mux = wake_mask;
      `IDX_REG_FAULT_FLAG:   rd_mux = fault_flag;
      `IDX_SUPPLY_WAKE_FLAG: rd_mux = wake_flag;
      default:               rd_mux = {REG_W{1'b0}};
    endcase
  end

  // A read beside a write to the same index returns the value before the write
  // Unmapped indices read zero and raise a one-cycle error pulse
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q    <= {REG_W{1'b0}};
      rd_valid_q <= 1'b0;
      idx_err_q  <= 1'b0;
    end else if (clk_en) begin
      rd_valid_q <= reg_rd;
      idx_err_q  <= (reg_rd | reg_wr) & ~sel_any;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign reg_idx_err  = idx_err_q;

endmodule // pmic_interrupt_mask_bank

// File: hw/int_mask_defs.vh
// Constants for the interrupt mask bank: register indices, field positions, reset values
`ifndef INT_MASK_DEFS_VH
`define INT_MASK_DEFS_VH

// ==========================================================================
// Register indices on the internal register port
// ==========================================================================
`define IDX_W                    4
`define IDX_REG_FAULT_MASK       4'h8
`define IDX_SUPPLY_WAKE_MASK     4'h9
`define IDX_REG_FAULT_FLAG       4'hA
`define IDX_SUPPLY_WAKE_FLAG     4'hB

// ==========================================================================
// Data word: register bits 23..8 travel as data bits 15..0
// ==========================================================================
`define REG_W                    16
`define REG_LSB                  8

// ==========================================================================
// First mask register, printed bit positions
// ==========================================================================
`define POS_PREREG_OC            22
`define POS_CORE_BUCK_OC         20
`define POS_AUX_BUCK_OC          18
`define POS_LINEAR_OC            17
`define POS_CORE_BUCK_THERMAL    12
`define POS_AUX_BUCK_THERMAL     10
`define POS_LINEAR_THERMAL       9

// ==========================================================================
// Second mask register, printed bit positions
// ==========================================================================
`define POS_INT_SUPPLY_UVH       18
`define POS_COM_ERROR            17
`define POS_PREREG_FB_OV         16
`define POS_BATTERY_UV7          14
`define POS_UVH_A                12
`define POS_BATTERY_UVL          11
`define POS_UVH_B                10
`define POS_FIRST_WAKE           9
`define POS_SECOND_WAKE          8

// ==========================================================================
// Implemented bits and reset values
// ==========================================================================
`define REG_FAULT_BITS           16'h5616
`define SUPPLY_WAKE_BITS         16'h075F
`define MASK_RESET               16'h0000
`define FLAG_RESET               16'h0000

`endif

// File: hw/mask_register.v
// Software-written mask register with a fixed set of implemented bits
`timescale 1ns/1ps

module mask_register #(
  parameter        WIDTH     = 16,
  parameter [15:0] IMPL_BITS = 16'hFFFF,
  parameter [15:0] RST_VAL   = 16'h0000
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire             clk_en,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output wire [WIDTH-1:0] mask
);

  reg [WIDTH-1:0] mask_q;

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Reserved positions never store a one, so they always read as zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= RST_VAL[WIDTH-1:0];
    end else if (clk_en && wr_en) begin
      mask_q <= wr_data & IMPL_BITS[WIDTH-1:0];
    end
  end

  assign mask = mask_q;

endmodule // mask_register

// File: hw/sticky_flags.v
// Sticky event flags, cleared by writing one, with set winning over clear
`timescale 1ns/1ps

module sticky_flags #(
  parameter        WIDTH     = 16,
  parameter [15:0] IMPL_BITS = 16'hFFFF,
  parameter [15:0] RST_VAL   = 16'h0000
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] set_evt,
  input  wire             clr_en,
  input  wire [WIDTH-1:0] clr_data,
  output wire [WIDTH-1:0] flags
);

  reg  [WIDTH-1:0] flags_q;
  wire [WIDTH-1:0] clr_bits;
  wire [WIDTH-1:0] flags_d;

  // ==========================================================================
  // Update
  // ==========================================================================
  assign clr_bits = clr_en ? clr_data : {WIDTH{1'b0}};
  // An event in the clearing cycle survives the clear
  assign flags_d  = ((flags_q & ~clr_bits) | set_evt) & IMPL_BITS[WIDTH-1:0];

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= RST_VAL[WIDTH-1:0];
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule // sticky_flags

// File: verification/mask_bank_chk_sva.sv
// Port-level assertions for the interrupt mask bank
`timescale 1ns/1ps

module mask_bank_chk #(
  parameter IDX_W = 4,
  parameter REG_W = 16
) (
  input wire logic             mclk,
  input wire logic             rst_b,
  input wire logic             clk_en,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [IDX_W-1:0] reg_idx,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic [REG_W-1:0] reg_rdata,
  input wire logic             reg_rd_valid,
  input wire logic             reg_idx_err,
  input wire logic             prereg_overcurrent_evt,
  input wire logic             int_req,
  input wire logic [REG_W-1:0] regulator_fault_interrupt_mask,
  input wire logic [REG_W-1:0] supply_wake_interrupt_mask
);
  // ==========================================================================
  // Sequences
  // ==========================================================================
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_one;
    clk_en && reg_wr && reg_idx == 4'h8;
  endsequence
  sequence s_wr_two;
    clk_en && reg_wr && reg_idx == 4'h9;
  endsequence
  // Event taken, then a cycle later the mask still lets it through
  sequence s_oc_unmasked;
    clk_en && prereg_overcurrent_evt ##1 clk_en && !regulator_fault_interrupt_mask[14];
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_mask_one_write:
    assert property (s_wr_one |=> regulator_fault_interrupt_mask == ($past(reg_wdata) & 16'h5616))
    else $error("mask one write not stored as implemented bits");
  a_mask_two_write:
    assert property (s_wr_two |=> supply_wake_interrupt_mask == ($past(reg_wdata) & 16'h075F))
    else $error("mask two write not stored as implemented bits");
  a_mask_one_hold:
    assert property (!(clk_en && reg_wr && reg_idx == 4'h8) |=> $stable(regulator_fault_interrupt_mask))
    else $error("mask one changed without a write");
  a_read_answer:
    assert property (clk_en && reg_rd |=> reg_rd_valid)
    else $error("read not answered after one cycle");
  a_valid_cause:
    assert property ($rose(reg_rd_valid) |-> $past(reg_rd))
    else $error("read valid without a read");
  a_read_mask_two:
    assert property (clk_en && reg_rd && reg_idx == 4'h9 |=> reg_rdata == $past(supply_wake_interrupt_mask))
    else $error("mask two read data wrong");
  a_idx_refused:
    assert property (clk_en && (reg_wr || reg_rd) && (reg_idx < 4'h8 || reg_idx > 4'hB) |=> reg_idx_err)
    else $error("unmapped index not flagged");
  a_all_masked_quiet:
    assert property (clk_en && regulator_fault_interrupt_mask == 16'h5616 &&
                     supply_wake_interrupt_mask == 16'h075F |=> !int_req)
    else $error("interrupt raised with every source masked");
  a_oc_raises_int:
    assert property (s_oc_unmasked |=> int_req)
    else $error("unmasked overcurrent did not raise interrupt");
endmodule // mask_bank_chk

bind pmic_interrupt_mask_bank mask_bank_chk #(.IDX_W(IDX_W), .REG_W(REG_W)) u_chk (.*);

// File: verification/host_model.sv
// Host microcontroller model driving the register port
`timescale 1ns/1ps

module host_model (
  input  wire        mclk,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [3:0]  reg_idx,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata,
  input  wire        reg_rd_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 4'h0;
    reg_wdata = 16'h0000;
  end

  // Released lines are inverted so a stale value can never look valid
  task automatic wr(input logic [3:0] idx, input logic [15:0] data);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_idx <= idx;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_idx <= ~idx;
    reg_wdata <= ~data;
  endtask

  task automatic rd(input logic [3:0] idx, output logic [15:0] data, output logic vld);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_idx <= idx;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_idx <= ~idx;
    #1;
    vld = reg_rd_valid;
    data = reg_rdata;
  endtask
endmodule // host_model

// File: verification/tb.sv
// Self-checking testbench for the interrupt mask bank
`timescale 1ns/1ps

module tb;
  logic        mclk;
  logic        rst_b;
  logic        clk_en;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_idx;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rd_valid;
  logic        reg_idx_err;
  logic        int_req;
  logic [15:0] regulator_fault_interrupt_mask;
  logic [15:0] supply_wake_interrupt_mask;
  logic [11:0] evt;
  logic [3:0]  lvl;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Data bit of each source: 12 pulse events, then the 4 level inputs
  localparam int bitpos [16] = '{14, 12, 10, 9, 4, 2, 1, 8, 6, 4, 3, 2, 10, 9, 1, 0};

  pmic_interrupt_mask_bank u_dut (
    .mclk, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_idx_err,
    .prereg_overcurrent_evt(evt[0]), .core_buck_overcurrent_evt(evt[1]), .aux_buck_overcurrent_evt(evt[2]),
    .linear_overcurrent_evt(evt[3]), .core_buck_thermal_shutdown_evt(evt[4]),
    .aux_buck_thermal_shutdown_evt(evt[5]), .linear_thermal_shutdown_evt(evt[6]),
    .prereg_feedback_ov_evt(evt[7]), .battery_supply_uv7_evt(evt[8]), .pre_regulator_uv_high_evt(evt[9]),
    .battery_supply_uv_low_evt(evt[10]), .battery_supply_uv_high_evt(evt[11]),
    .internal_supply_uv_high(lvl[0]), .com_error(lvl[1]), .first_wake_input(lvl[2]),
    .second_wake_input(lvl[3]), .int_req, .regulator_fault_interrupt_mask, .supply_wake_interrupt_mask
  );
  host_model u_host (.mclk, .reg_wr, .reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .reg_rd_valid);

  // ==========================================================================
  // Compare and report
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_host.rd(idx, d, v);
    chk({what, " valid"}, 16'h0001, {15'h0000, v});
    chk(what, exp, d);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset;
    rd_chk("mask one", 4'h8, 16'h0000);
    rd_chk("mask two", 4'h9, 16'h0000);
    rd_chk("flags one", 4'hA, 16'h0000);
    rd_chk("flags two", 4'hB, 16'h0000);
    chk("int_req", 16'h0000, {15'h0000, int_req});
  endtask

  task automatic t_mask_rw;
    u_host.wr(4'h8, 16'hFFFF);
    u_host.wr(4'h9, 16'hFFFF);
    rd_chk("mask one", 4'h8, 16'h5616);
    rd_chk("mask two", 4'h9, 16'h075F);
    @(posedge mclk) clk_en <= 1'b0;
    u_host.wr(4'h8, 16'h0000);
    @(posedge mclk) clk_en <= 1'b1;
    #1;
    chk("mask one frozen", 16'h5616, regulator_fault_interrupt_mask);
    u_host.wr(4'h8, 16'h0000);
    u_host.wr(4'h9, 16'h0000);
    #1;
    chk("mask two cleared", 16'h0000, supply_wake_interrupt_mask);
    u_host.wr(4'h3, 16'hFFFF);
    #1;
    chk("idx err write", 16'h0001, {15'h0000, reg_idx_err});
    rd_chk("unmapped read", 4'hF, 16'h0000);
    chk("idx err read", 16'h0001, {15'h0000, reg_idx_err});
  endtask

  // Levels toggle, so each level source is exercised rising and falling
  task automatic fire(input int i);
    @(posedge mclk);
    if (i < 12)
      evt[i] <= 1'b1;
    else
      lvl[i-12] <= ~lvl[i-12];
    @(posedge mclk);
    evt <= 12'h000;
  endtask

  task automatic t_sources;
    logic [3:0]  midx;
    logic [15:0] b;
    for (int i = 0; i < 16; i++) begin
      midx = (i < 7) ? 4'h8 : 4'h9;
      b = 16'h0001 << bitpos[i];
      for (int m = 0; m < 2; m++) begin
        u_host.wr(midx, m ? b : 16'h0000);
        fire(i);
        @(posedge mclk);
        #1;
        chk($sformatf("int_req src %0d mask %0d", i, m), m ? 16'h0000 : 16'h0001, {15'h0000, int_req});
        rd_chk($sformatf("flag src %0d", i), midx + 4'h2, b);
        u_host.wr(midx + 4'h2, b);
        @(posedge mclk);
        #1;
        chk($sformatf("int_req clear src %0d", i), 16'h0000, {15'h0000, int_req});
      end
      u_host.wr(midx, 16'h0000);
    end
  endtask

  // An event in the very cycle of its clear must not be lost
  task automatic t_set_wins;
    fork
      u_host.wr(4'hA, 16'h4000);
      fire(0);
    join
    rd_chk("flag set wins", 4'hA, 16'h4000);
    u_host.wr(4'hA, 16'h4000);
    rd_chk("flag cleared", 4'hA, 16'h0000);
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Whole run needs about 410 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    evt = 12'h000;
    lvl = 4'h0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_mask_rw;
    t_sources;
    t_set_wins;
    final_report;
  end
endmodule // tb
